// ===== hdl/gcsm_mux.sv
// Glitchless two-source clock switch: staged handover or plain multiplexer.
// Assumes sources, select and strap are synchronous to mclk.
`default_nettype none

module gcsm_mux #(
    parameter int unsigned OLD_MAX   = gcsm_pkg::OLD_PULSE_MAX,
    parameter int unsigned LOW_EDGES = gcsm_pkg::NEW_LOW_EDGES,
    parameter int unsigned POR_LEN   = gcsm_pkg::POR_CYCLES
) (
    input  wire logic mclk,                    // Sampling clock, 125 MHz
    input  wire logic rst,                     // Asynchronous reset
    input  wire logic ce,                      // Clock enable
    input  wire logic first_clock_pair,        // First source level
    input  wire logic second_clock_pair,       // Second source level
    input  wire logic first_low_swing_guard,   // First source invalid
    input  wire logic second_low_swing_guard,  // Second source invalid
    input  wire logic sel,                     // Source select
    input  wire logic startup_delay_pin,       // High: tied to supply
    output logic      clk_out_ff,              // Switched clock output
    output logic      por_done_ff,             // Power-on reset finished
    output logic      busy_ff                  // Handover in progress
);
    import gcsm_pkg::*;

    // Parameter checks at elaboration
    generate
        if (OLD_MAX < 1 || LOW_EDGES < 1 ||
            OLD_MAX + LOW_EDGES + 2 > HANDOVER_MAX) begin : g_bad_stage
            $error("Handover stages exceed the handover bound");
        end
        if (POR_LEN < 1 || POR_LEN >= (1 << POR_CNT_W)) begin : g_bad_por
            $error("Power-on reset length does not fit its counter");
        end
    endgenerate

    localparam logic [STG_CNT_W-1:0] OLD_LAST =
        STG_CNT_W'(OLD_MAX - 1);           // Last old-clock count
    localparam logic [STG_CNT_W-1:0] LOW_LAST =
        STG_CNT_W'(LOW_EDGES - 1);         // Last low-hold count
    localparam logic [POR_CNT_W-1:0] POR_LAST =
        POR_CNT_W'(POR_LEN - 1);           // Last power-on count

    logic [1:0]           raw_clk;         // Both source levels
    logic [1:0]           raw_guard;       // Both amplitude flags
    logic [1:0]           lvl;             // Held valid levels
    logic [1:0]           rise;            // Rising edge pulses
    logic [1:0]           fall;            // Falling edge pulses
    gcsm_state_t          state_ff;        // Handover state
    logic                 active_ff;       // Source being followed
    logic                 target_ff;       // Source being moved to
    logic                 bypass_ff;       // Suppression off
    logic [STG_CNT_W-1:0] stg_cnt_ff;      // Stage edge counter
    logic [POR_CNT_W-1:0] por_cnt_ff;      // Power-on counter

    // Pick one bit of a source pair by index
    function automatic logic pick(input logic [1:0] v, input logic idx);
        pick = idx ? v[1] : v[0];
    endfunction : pick

    assign raw_clk   = {second_clock_pair, first_clock_pair};
    assign raw_guard = {second_low_swing_guard, first_low_swing_guard};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_src
            gcsm_level_hold u_hold (
                .mclk   (mclk),
                .rst    (rst),
                .ce     (ce),
                .clk_in (raw_clk[gi]),
                .guard  (raw_guard[gi]),
                .lvl_ff (lvl[gi]),
                .rise_ff(rise[gi]),
                .fall_ff(fall[gi])
            );
        end
    endgenerate

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            por_cnt_ff  <= '0;
            por_done_ff <= 1'b0;
        end else if (ce && !por_done_ff) begin
            // Count out the start-up delay, then release
            if (por_cnt_ff == POR_LAST) begin
                por_done_ff <= 1'b1;
            end else begin
                por_cnt_ff <= por_cnt_ff + POR_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bypass_ff <= 1'b0;
        end else if (ce && !por_done_ff) begin
            // Strap sampled throughout start-up, frozen afterwards
            bypass_ff <= startup_delay_pin;
        end
    end

    // Handover state machine
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_ff   <= GCSM_FOLLOW;
            active_ff  <= SRC_RST;
            target_ff  <= SRC_RST;
            stg_cnt_ff <= '0;
        end else if (ce) begin
            if (!por_done_ff) begin
                active_ff  <= sel;
                target_ff  <= sel;
                state_ff   <= GCSM_FOLLOW;
                stg_cnt_ff <= '0;
            end else if (bypass_ff) begin
                active_ff <= sel;
                target_ff <= sel;
                state_ff  <= GCSM_FOLLOW;
            end else begin
                case (state_ff)
                    GCSM_FOLLOW: begin
                        // New selection starts a handover
                        if (sel != active_ff) begin
                            target_ff  <= sel;
                            stg_cnt_ff <= '0;
                            state_ff   <= GCSM_DRAIN;
                        end
                    end
                    GCSM_DRAIN: begin
                        if (!pick(lvl, active_ff)) begin
                            stg_cnt_ff <= '0;
                            state_ff   <= GCSM_HOLD;
                        end else if (stg_cnt_ff == OLD_LAST) begin
                            // stuck high drops on new fall
                            if (pick(fall, target_ff)) begin
                                stg_cnt_ff <= '0;
                                state_ff   <= GCSM_HOLD;
                            end
                        end else if (pick(rise, target_ff)) begin
                            stg_cnt_ff <= stg_cnt_ff + STG_CNT_W'(1);
                        end
                    end
                    GCSM_HOLD: begin
                        if (pick(fall, target_ff)) begin
                            if (stg_cnt_ff == LOW_LAST) begin
                                active_ff <= target_ff;
                                state_ff  <= GCSM_FOLLOW;
                            end else begin
                                stg_cnt_ff <= stg_cnt_ff + STG_CNT_W'(1);
                            end
                        end
                    end
                    default: begin
                        // Recover from an illegal code
                        state_ff   <= GCSM_FOLLOW;
                        stg_cnt_ff <= '0;
                    end
                endcase
            end
        end
    end

    // Output clock drive
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            clk_out_ff <= LEVEL_RST;
        end else if (ce) begin
            if (!por_done_ff) begin
                // Quiet while starting up
                clk_out_ff <= LEVEL_RST;
            end else if (bypass_ff) begin
                clk_out_ff <= pick(lvl, sel);
            end else begin
                case (state_ff)
                    GCSM_FOLLOW: clk_out_ff <= pick(lvl, active_ff);
                    GCSM_DRAIN: begin
                        // old high kept until a new fall
                        if (stg_cnt_ff == OLD_LAST && pick(fall, target_ff)) begin
                            clk_out_ff <= 1'b0;
                        end else begin
                            clk_out_ff <= pick(lvl, active_ff);
                        end
                    end
                    GCSM_HOLD:   clk_out_ff <= 1'b0;
                    default:     clk_out_ff <= 1'b0;
                endcase
            end
        end
    end

    // Busy flag: high while a handover is in flight
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy_ff <= 1'b0;
        end else if (ce) begin
            busy_ff <= por_done_ff && !bypass_ff &&
                       (state_ff != GCSM_FOLLOW || sel != active_ff);
        end
    end
endmodule : gcsm_mux

`default_nettype wire

// ===== hdl/gcsm_pkg.sv
// Constants shared by the glitchless clock switch mux design.
// Assumes a single 125 MHz sampling clock; both sources are sampled levels.
`default_nettype none

package gcsm_pkg;
    // Sampling clock period in picoseconds
    localparam int unsigned CLK_PERIOD_PS   = 8000;
    // Internal power-on reset time in nanoseconds
    localparam int unsigned POR_TIME_NS     = 1000;
    // Power-on reset length in clock cycles (rounded up, at least one)
    localparam int unsigned POR_CYCLES      =
        ((POR_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS < 1) ? 1 :
        (POR_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Width of the power-on reset counter
    localparam int unsigned POR_CNT_W       = 12;
    // Longest handover, in cycles of the newly selected clock
    localparam int unsigned HANDOVER_MAX    = 17;
    // Default new-clock rising edges the old clock may still be followed
    localparam int unsigned OLD_PULSE_MAX   = 4;
    // Default new-clock falling edges the output stays low
    localparam int unsigned NEW_LOW_EDGES   = 3;
    // Width of the handover stage counter
    localparam int unsigned STG_CNT_W       = 5;
    // Reset value of the held input levels and of the output
    localparam logic        LEVEL_RST       = 1'b0;
    // Reset value of the source index (first clock pair)
    localparam logic        SRC_RST         = 1'b0;

    // Handover states, one-hot
    typedef enum logic [2:0] {
        GCSM_FOLLOW = 3'b001, // Output follows the active source
        GCSM_DRAIN  = 3'b010, // Old source still followed until it falls
        GCSM_HOLD   = 3'b100  // Output parked low, counting new falls
    } gcsm_state_t;
endpackage : gcsm_pkg

`default_nettype wire

// ===== hdl/gcsm_level_hold.sv
// One input stage: holds the last valid level of a source clock and flags
// its edges. Assumes the source is synchronous to mclk.
`default_nettype none

module gcsm_level_hold (
    input  wire logic mclk,        // Sampling clock
    input  wire logic rst,         // Asynchronous reset, active high
    input  wire logic ce,          // Clock enable, freezes state when low
    input  wire logic clk_in,      // Sampled source clock level
    input  wire logic guard,       // Source below valid amplitude
    output logic      lvl_ff,      // Last valid level
    output logic      rise_ff,     // One-cycle pulse on rising edge
    output logic      fall_ff      // One-cycle pulse on falling edge
);
    import gcsm_pkg::*;

    logic nxt_lvl;                 // Level to hold next

    always_comb begin
        nxt_lvl = guard ? lvl_ff : clk_in;
    end

    // Held level and edge flags
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lvl_ff  <= LEVEL_RST;
            rise_ff <= 1'b0;
            fall_ff <= 1'b0;
        end else if (ce) begin
            lvl_ff  <= nxt_lvl;
            rise_ff <= nxt_lvl & ~lvl_ff;
            fall_ff <= ~nxt_lvl & lvl_ff;
        end
    end
endmodule : gcsm_level_hold

`default_nettype wire

// ===== test/gcsm_mux_asserts.sv
// Port checker for gcsm_mux, bound into every instance.
// Assumes sources with a half period of 4 mclk cycles.
`default_nettype none
module gcsm_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic first_clock_pair,
    input wire logic second_clock_pair,
    input wire logic first_low_swing_guard,
    input wire logic second_low_swing_guard,
    input wire logic sel,
    input wire logic startup_delay_pin,
    input wire logic clk_out_ff,
    input wire logic por_done_ff,
    input wire logic busy_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    // Longest handover: 17 new-clock periods of 8 mclk cycles
    localparam int HO_MAX = 136;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    AST_POR_LOW: assert property (!por_done_ff |-> !clk_out_ff)
        else $error("output active during power-on");
    AST_BYP_FOLLOW: assert property (
        startup_delay_pin && $past(por_done_ff, 2) &&
        !$past(first_low_swing_guard, 2) &&
        !$past(second_low_swing_guard, 2) |-> clk_out_ff == ($past(sel) ?
        $past(second_clock_pair, 2) : $past(first_clock_pair, 2)))
        else $error("plain mux output wrong");
    AST_BYP_IDLE: assert property (
        startup_delay_pin && por_done_ff |-> !busy_ff)
        else $error("handover while suppression off");
    AST_NO_SHORT_HI: assert property (
        !startup_delay_pin && $past(por_done_ff, 3) && $rose(clk_out_ff)
        |-> clk_out_ff[*4])
        else $error("short high pulse");
    AST_NO_SHORT_LO: assert property (
        !startup_delay_pin && $past(por_done_ff, 3) && $fell(clk_out_ff)
        |-> !clk_out_ff[*4])
        else $error("short low pulse");
    AST_BUSY_START: assert property (
        !startup_delay_pin && $past(por_done_ff) && !busy_ff &&
        $changed(sel) |-> ##[1:2] busy_ff)
        else $error("handover not started");
    AST_BUSY_BOUND: assert property (
        $rose(busy_ff) |-> ##[1:HO_MAX] !busy_ff)
        else $error("handover too long");
    AST_HOLD_FIRST: assert property (
        (!sel && !busy_ff && first_low_swing_guard)[*3]
        |-> $stable(clk_out_ff))
        else $error("dead first source toggles output");
    AST_HOLD_SECOND: assert property (
        (sel && !busy_ff && second_low_swing_guard)[*3]
        |-> $stable(clk_out_ff))
        else $error("dead second source toggles output");
    // Main scenarios reached
    COV_HANDOVER: cover property ($rose(busy_ff));
    COV_BYPASS: cover property (startup_delay_pin && $changed(sel));
    COV_GUARD: cover property (first_low_swing_guard && !sel);
    COV_GUARD_SECOND: cover property (second_low_swing_guard && sel);
    COV_FREEZE: cover property (!ce && por_done_ff);
endmodule : gcsm_chk
bind gcsm_mux gcsm_chk u_chk (.mclk(mclk), .rst(rst), .ce(ce),
    .first_clock_pair(first_clock_pair),
    .second_clock_pair(second_clock_pair),
    .first_low_swing_guard(first_low_swing_guard),
    .second_low_swing_guard(second_low_swing_guard), .sel(sel),
    .startup_delay_pin(startup_delay_pin), .clk_out_ff(clk_out_ff),
    .por_done_ff(por_done_ff), .busy_ff(busy_ff));
`default_nettype wire

// ===== test/gcsm_src_model.sv
// Two source clocks of equal period, the second skewed in phase.
// A dead source toggles every cycle, since its level is worthless.
`default_nettype none
module gcsm_src_model #(
    parameter int HALF = 4,  // Half period in mclk cycles
    parameter int SKEW = 3   // Phase offset of the second source
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic dead_first,
    input  wire logic dead_second,
    output logic      src_first,
    output logic      src_second
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_ff; // Phase counter
    // Step the phase and drive both levels just after the edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_ff <= 0;
            src_first <= 1'b0;
            src_second <= 1'b0;
        end else begin
            cnt_ff <= (cnt_ff + 1) % (2 * HALF);
            src_first <= dead_first ? !src_first : (cnt_ff < HALF);
            src_second <= dead_second ? !src_second :
                (((cnt_ff + SKEW) % (2 * HALF)) < HALF);
        end
    end
endmodule : gcsm_src_model
`default_nettype wire

// ===== test/gcsm_mux_tb.sv
// Self-checking bench for gcsm_mux; the bench is the select controller.
// Assumes POR_LEN of 2 and sources of 8 mclk period.
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value at %0t: %h exp %h", $time, a, b); end end
module gcsm_mux_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst = 1, sel = 0, strap = 0, g1 = 0, g2 = 0;
    logic ce = 1; // Clock enable driven by the bench
    logic s1, s2, clk_out, por_done, busy;
    logic [1:0] d1, d2; // Sources sampled one and two edges back
    int n_fail = 0, n_tests = 0, cyc = 0;
    always #4 mclk = ~mclk;
    gcsm_src_model u_src (.mclk(mclk), .rst(rst), .dead_first(g1),
        .dead_second(g2), .src_first(s1), .src_second(s2));
    gcsm_mux #(.POR_LEN(2)) dut (.mclk(mclk), .rst(rst), .ce(ce),
        .first_clock_pair(s1), .second_clock_pair(s2),
        .first_low_swing_guard(g1), .second_low_swing_guard(g2),
        .sel(sel), .startup_delay_pin(strap), .clk_out_ff(clk_out),
        .por_done_ff(por_done), .busy_ff(busy));
    // Source history and the cycle ceiling
    always @(posedge mclk) begin
        d1 <= {s2, s1};
        d2 <= d1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end
    task automatic results();
        if (n_fail == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    // Output equals the chosen source two edges back
    task automatic follow(input int which, input int n);
        repeat (n) begin
            @(negedge mclk);
            `CHK(clk_out, d2[which])
        end
    endtask : follow
    task automatic do_reset(input logic tie);
        @(posedge mclk);
        rst <= 1'b1;
        strap <= tie;
        sel <= 1'b0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
        `CHK({por_done, clk_out}, 2'b00)
        @(negedge mclk);
        `CHK(por_done, 1'b1)
        repeat (2) @(negedge mclk);
        follow(0, 8);
    endtask : do_reset
    task automatic t_switch(input logic to);
        int n;
        n = 0;
        @(posedge mclk);
        sel <= to;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        `CHK(busy, 1'b1)
        while (busy === 1'b1 && n < 400) begin
            @(negedge mclk);
            n++;
        end
        `CHK(n <= gcsm_pkg::HANDOVER_MAX * 8, 1'b1)
        follow(to, 24);
    endtask : t_switch
    // Kill the selected source; output must hold its last level
    task automatic t_guard(input int which);
        logic held;
        @(posedge mclk);
        if (which == 1) begin
            g2 <= 1'b1;
        end else begin
            g1 <= 1'b1;
        end
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        held = clk_out;
        repeat (12) begin
            @(negedge mclk);
            `CHK(clk_out, held)
        end
    endtask : t_guard
    // Freeze for one source period; output stands, then resumes in phase
    task automatic t_freeze();
        logic held;
        @(posedge mclk);
        ce <= 1'b0;
        @(negedge mclk);
        held = clk_out;
        repeat (7) begin
            @(negedge mclk);
            `CHK(clk_out, held)
        end
        @(posedge mclk);
        ce <= 1'b1;
        @(negedge mclk);
        `CHK(clk_out, held)
        follow(sel, 8);
    endtask : t_freeze
    task automatic t_bypass();
        do_reset(1'b1);
        repeat (3) begin
            @(posedge mclk);
            sel <= ~sel;
            @(negedge mclk);
            follow(sel, 6);
            `CHK(busy, 1'b0)
        end
    endtask : t_bypass
    initial begin
        do_reset(1'b0);
        t_switch(1'b1);
        t_switch(1'b0);
        t_guard(0);
        t_switch(1'b1);
        @(posedge mclk);
        g1 <= 1'b0;
        t_guard(1);
        t_switch(1'b0);
        @(posedge mclk);
        g2 <= 1'b0;
        t_freeze();
        t_bypass();
        results();
    end
endmodule : gcsm_mux_tb
`default_nettype wire
